//--- design/psc_pkg.sv
// Constants shared by both ends of the protocol sequence status link.
package psc_pkg;
  localparam int PORTS     = 2;
  localparam int CLK_HZ    = 40_000_000;
  localparam int ABORT_MS  = 15;
  localparam int MS_PER_S  = 1000;
  // A least time, so the cycle count rounds up.
  localparam int ABORT_CYC = (ABORT_MS * (CLK_HZ / MS_PER_S) * MS_PER_S + MS_PER_S - 1) / MS_PER_S;
  localparam int SCAN_CYC  = 40_000;
  localparam int CNT_W     = 21;
  localparam int CASE_W    = 4;
  localparam int REP_W     = 8;
  localparam int DATA_W    = 8;
  localparam int ADDR_W    = 4;
  localparam int AXI_W     = 32;
  localparam int LANE_W    = 8;
  localparam int INFO_W    = 16;
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_INFO   = 4'h8;
  localparam int CTL_RUN     = 0;
  localparam int CTL_ABORT   = 1;
  localparam int CTL_RESTART = 2;
  localparam int ST_EXEC     = 0;
  localparam int ST_STEP_ERR = 1;
  localparam int ST_END      = 2;
  localparam int ST_ABORT    = 3;
  localparam int ST_RESTART  = 4;
  localparam int ST_STORED   = 5;
  localparam int ST_CONFLICT = 6;
  localparam int ST_REJECT   = 7;
  localparam int INF_CASE    = 0;
  localparam int INF_STEP    = 4;
  localparam int INF_REP     = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- design/special_status_area_if.sv
// Interface joining the host end and the communications board end.
`timescale 1ns/100ps
interface special_status_area_if;
  logic [psc_pkg::PORTS-1:0]                     run_protocol_sequence;
  logic [psc_pkg::PORTS-1:0]                     abort_bit;
  logic [psc_pkg::PORTS-1:0]                     restart_req;
  logic [psc_pkg::PORTS-1:0]                     exec_flag;
  logic [psc_pkg::PORTS-1:0]                     step_err_flag;
  logic [psc_pkg::PORTS-1:0]                     seq_end_flag;
  logic [psc_pkg::PORTS-1:0]                     seq_abort_flag;
  logic [psc_pkg::PORTS-1:0]                     restart_bit;
  logic [psc_pkg::PORTS-1:0]                     stored_flag;
  logic [psc_pkg::PORTS-1:0]                     sequence_conflict_fatal_error;
  logic [psc_pkg::PORTS-1:0]                     run_rejected;
  logic [psc_pkg::PORTS-1:0][psc_pkg::CASE_W-1:0] case_no;
  logic [psc_pkg::PORTS-1:0][psc_pkg::CASE_W-1:0] step_no;
  logic [psc_pkg::PORTS-1:0][psc_pkg::REP_W-1:0]  repeat_cnt;

  modport dev (
    input  run_protocol_sequence, abort_bit, restart_req,
    output exec_flag, step_err_flag, seq_end_flag, seq_abort_flag, restart_bit,
    output stored_flag, sequence_conflict_fatal_error, run_rejected,
    output case_no, step_no, repeat_cnt
  );
  modport host (
    output run_protocol_sequence, abort_bit, restart_req,
    input  exec_flag, step_err_flag, seq_end_flag, seq_abort_flag, restart_bit,
    input  stored_flag, sequence_conflict_fatal_error, run_rejected,
    input  case_no, step_no, repeat_cnt
  );
endinterface

//--- design/comm_board_end.sv
// Communications board end: per-port sequence status, abort and restart.
`timescale 1ns/100ps
// How it works
// - Accepted invocation sets execution flag
// - Sequence completion or abort clears execution flag
// - Failed step sets error, successful retry clears
// - Normal end flag set by end processing
// - Aborted flag set by abort processing or engine abort
// - Host abort bit triggers abort processing
// - Restart reinitialises buffers and status words
// - Restart never cancels a running sequence
// - Restart bit clears itself when done
// - Store selected reception case number
// - Case or step store sets stored flag
// - Publish repeat counter present value
// - Abort bit drops execution flag at once
// - Abort released too early skips processing
// - Invocation during abort processing is fatal
// - Half duplex; clear receive buffer at boundaries
// - Discard characters arriving around send
// - Invocation while running is rejected, fatal if restart pending
// - Step error stays set after later steps
module comm_board_end #(
  parameter int ABORT_CYC = psc_pkg::ABORT_CYC
) (
  // Clock and reset
  input  wire logic                                           clk,
  input  wire logic                                           rst,
  // Status link to the host
  special_status_area_if.dev                                  ssa,
  // Sequence engine control
  output logic       [psc_pkg::PORTS-1:0]                     seq_start,
  output logic       [psc_pkg::PORTS-1:0]                     seq_stop,
  output logic       [psc_pkg::PORTS-1:0]                     buf_init,
  output logic       [psc_pkg::PORTS-1:0]                     rx_clear,
  // Sequence engine events
  input  wire logic  [psc_pkg::PORTS-1:0]                     step_fail,
  input  wire logic  [psc_pkg::PORTS-1:0]                     step_retry_ok,
  input  wire logic  [psc_pkg::PORTS-1:0]                     seq_done_ok,
  input  wire logic  [psc_pkg::PORTS-1:0]                     seq_done_abort,
  input  wire logic  [psc_pkg::PORTS-1:0]                     case_wr,
  input  wire logic  [psc_pkg::PORTS-1:0][psc_pkg::CASE_W-1:0] case_val,
  input  wire logic  [psc_pkg::PORTS-1:0]                     step_wr,
  input  wire logic  [psc_pkg::PORTS-1:0][psc_pkg::CASE_W-1:0] step_val,
  input  wire logic  [psc_pkg::PORTS-1:0][psc_pkg::REP_W-1:0]  rep_val,
  // Line side
  input  wire logic  [psc_pkg::PORTS-1:0]                     send_busy,
  input  wire logic  [psc_pkg::PORTS-1:0]                     rx_valid,
  input  wire logic  [psc_pkg::PORTS-1:0][psc_pkg::DATA_W-1:0] rx_data,
  output logic       [psc_pkg::PORTS-1:0]                     rx_out_valid,
  output logic       [psc_pkg::PORTS-1:0][psc_pkg::DATA_W-1:0] rx_out_data
);
  localparam int NP = psc_pkg::PORTS;
  localparam int CW = psc_pkg::CNT_W;
  localparam int KW = psc_pkg::CASE_W;
  localparam int RW = psc_pkg::REP_W;
  localparam int DW = psc_pkg::DATA_W;

  typedef struct packed {
    logic [NP-1:0]         exec;
    logic [NP-1:0]         step_err;
    logic [NP-1:0]         seq_end;
    logic [NP-1:0]         seq_abrt;
    logic [NP-1:0]         abusy;
    logic [NP-1:0]         abort_q;
    logic [NP-1:0]         restart;
    logic [NP-1:0]         stored;
    logic [NP-1:0]         fatal;
    logic [NP-1:0]         rej;
    logic [NP-1:0]         start;
    logic [NP-1:0]         stop;
    logic [NP-1:0]         rxclr;
    logic [NP-1:0]         init;
    logic [NP-1:0]         send_q;
    logic [NP-1:0]         rxv;
    logic [NP-1:0][CW-1:0] acnt;
    logic [NP-1:0][KW-1:0] case_no;
    logic [NP-1:0][KW-1:0] step_no;
    logic [NP-1:0][RW-1:0] rep;
    logic [NP-1:0][DW-1:0] rxd;
  } state_t;

  state_t q;
  state_t d;

  always_comb begin
    d       = q;
    d.fatal = '0;
    d.rej   = '0;
    d.start = '0;
    d.stop  = '0;
    d.rxclr = '0;
    d.init  = '0;
    d.rxv   = '0;
    // Each index is the loop's own port, so the ports never touch.
    for (int p = 0; p < NP; p++) begin
      d.abort_q[p] = ssa.abort_bit[p];
      d.send_q[p]  = send_busy[p];
      d.rep[p]     = rep_val[p];

      // Abort or restart work outranks a plain busy port.
      if (ssa.run_protocol_sequence[p]) begin
        if (q.abusy[p] || q.restart[p]) begin
          d.fatal[p] = 1'b1;
        end else if (q.exec[p]) begin
          d.rej[p] = 1'b1;
        end else begin
          d.exec[p]     = 1'b1;
          d.seq_end[p]  = 1'b0;
          d.seq_abrt[p] = 1'b0;
          d.step_err[p] = 1'b0;
          d.start[p]    = 1'b1;
          d.rxclr[p]    = 1'b1;
        end
      end

      // The abort bit drops the execution flag before processing finishes.
      if (ssa.abort_bit[p] && !q.abort_q[p] && q.exec[p]) begin
        d.exec[p]  = 1'b0;
        d.abusy[p] = 1'b1;
        d.acnt[p]  = '0;
      end else if (q.exec[p] && seq_done_ok[p]) begin
        d.exec[p]    = 1'b0;
        d.seq_end[p] = 1'b1;
      end else if (q.exec[p] && seq_done_abort[p]) begin
        d.exec[p]     = 1'b0;
        d.seq_abrt[p] = 1'b1;
      end

      // Abort processing needs the bit held throughout.
      if (q.abusy[p]) begin
        if (!ssa.abort_bit[p]) begin
          d.abusy[p] = 1'b0;
        end else if (q.acnt[p] == CW'(ABORT_CYC - 1)) begin
          d.abusy[p]    = 1'b0;
          d.seq_abrt[p] = 1'b1;
          d.stop[p]     = 1'b1;
        end else begin
          d.acnt[p] = q.acnt[p] + 1'b1;
        end
      end

      // Within a run only a retry clears the error; a later good step does not.
      if (q.exec[p] && step_retry_ok[p]) begin
        d.step_err[p] = 1'b0;
      end
      if (q.exec[p] && step_fail[p]) begin
        d.step_err[p] = 1'b1;
      end

      // Half duplex: the buffer restarts empty once the send has finished.
      if (q.send_q[p] && !send_busy[p]) begin
        d.rxclr[p] = 1'b1;
      end
      // Characters seen while sending, or in the cycle the send ends, are dropped.
      d.rxv[p] = rx_valid[p] && q.exec[p] && !send_busy[p] && !q.send_q[p];
      d.rxd[p] = rx_data[p];

      // Restart waits for the sequence and any abort processing to end.
      if (q.restart[p] && !q.exec[p] && !q.abusy[p]) begin
        d.restart[p] = 1'b0;
        d.init[p]    = 1'b1;
        d.rxclr[p]   = 1'b1;
        d.case_no[p] = '0;
        d.step_no[p] = '0;
        d.stored[p]  = 1'b0;
      end
      if (ssa.restart_req[p]) begin
        d.restart[p] = 1'b1;
      end

      // Stores come last so a store in the reinitialise cycle is not lost.
      if (case_wr[p]) begin
        d.case_no[p] = case_val[p];
        d.stored[p]  = 1'b1;
      end
      if (step_wr[p]) begin
        d.step_no[p] = step_val[p];
        d.stored[p]  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign ssa.exec_flag                     = q.exec;
  assign ssa.step_err_flag                 = q.step_err;
  assign ssa.seq_end_flag                  = q.seq_end;
  assign ssa.seq_abort_flag                = q.seq_abrt;
  assign ssa.restart_bit                   = q.restart;
  assign ssa.stored_flag                   = q.stored;
  assign ssa.sequence_conflict_fatal_error = q.fatal;
  assign ssa.run_rejected                  = q.rej;
  assign ssa.case_no                       = q.case_no;
  assign ssa.step_no                       = q.step_no;
  assign ssa.repeat_cnt                    = q.rep;
  assign seq_start                         = q.start;
  assign seq_stop                          = q.stop;
  assign buf_init                          = q.init;
  assign rx_clear                          = q.rxclr;
  assign rx_out_valid                      = q.rxv;
  assign rx_out_data                       = q.rxd;

endmodule // comm_board_end

//--- design/plc_cpu_end.sv
// Host end: AXI4-Lite registers driving the status link to the board.
`timescale 1ns/100ps
module plc_cpu_end #(
  parameter int HOLD_CYC = psc_pkg::ABORT_CYC + psc_pkg::SCAN_CYC
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // AXI4-Lite write channels
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [psc_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       wvalid,
  output logic                            wready,
  input  wire logic [psc_pkg::AXI_W-1:0]  wdata,
  input  wire logic [3:0]                 wstrb,
  output logic                            bvalid,
  input  wire logic                       bready,
  output logic      [1:0]                 bresp,
  // AXI4-Lite read channels
  input  wire logic                       arvalid,
  output logic                            arready,
  input  wire logic [psc_pkg::ADDR_W-1:0] araddr,
  output logic                            rvalid,
  input  wire logic                       rready,
  output logic      [psc_pkg::AXI_W-1:0]  rdata,
  output logic      [1:0]                 rresp,
  // Status link to the board
  special_status_area_if.host             ssa
);
  localparam int NP = psc_pkg::PORTS;
  localparam int CW = psc_pkg::CNT_W;
  localparam int LW = psc_pkg::LANE_W;
  localparam int IW = psc_pkg::INFO_W;

  typedef struct packed {
    logic                        aw_rdy;
    logic                        w_rdy;
    logic                        ar_rdy;
    logic                        awg;
    logic                        wg;
    logic [psc_pkg::ADDR_W-1:0]  awa;
    logic [psc_pkg::AXI_W-1:0]   wd;
    logic [3:0]                  ws;
    logic                        bv;
    logic [1:0]                  br;
    logic                        rv;
    logic [psc_pkg::AXI_W-1:0]   rd;
    logic [1:0]                  rr;
    logic [NP-1:0]               run;
    logic [NP-1:0]               abort_sw;
    logic [NP-1:0]               abort_out;
    logic [NP-1:0]               rst_req;
    logic [NP-1:0]               conflict;
    logic [NP-1:0]               reject;
    logic [NP-1:0][CW-1:0]       guard;
  } state_t;

  state_t q;
  state_t d;

  always_comb begin
    logic [psc_pkg::AXI_W-1:0] stat_w;
    logic [psc_pkg::AXI_W-1:0] info_w;
    logic [psc_pkg::AXI_W-1:0] ctrl_w;
    stat_w    = '0;
    info_w    = '0;
    ctrl_w    = '0;
    d         = q;
    d.run     = '0;
    d.rst_req = '0;
    for (int p = 0; p < NP; p++) begin
      ctrl_w[p*LW + psc_pkg::CTL_ABORT]   = q.abort_sw[p];
      stat_w[p*LW + psc_pkg::ST_EXEC]     = ssa.exec_flag[p];
      stat_w[p*LW + psc_pkg::ST_STEP_ERR] = ssa.step_err_flag[p];
      // Outcome flags count only once the execution flag is clear.
      stat_w[p*LW + psc_pkg::ST_END]      = ssa.seq_end_flag[p] && !ssa.exec_flag[p];
      stat_w[p*LW + psc_pkg::ST_ABORT]    = ssa.seq_abort_flag[p] && !ssa.exec_flag[p];
      stat_w[p*LW + psc_pkg::ST_RESTART]  = ssa.restart_bit[p];
      stat_w[p*LW + psc_pkg::ST_STORED]   = ssa.stored_flag[p];
      stat_w[p*LW + psc_pkg::ST_CONFLICT] = q.conflict[p];
      stat_w[p*LW + psc_pkg::ST_REJECT]   = q.reject[p];
      info_w[p*IW + psc_pkg::INF_CASE +: psc_pkg::CASE_W] = ssa.case_no[p];
      info_w[p*IW + psc_pkg::INF_STEP +: psc_pkg::CASE_W] = ssa.step_no[p];
      info_w[p*IW + psc_pkg::INF_REP +: psc_pkg::REP_W]   = ssa.repeat_cnt[p];
      if (q.guard[p] != '0) begin
        d.guard[p] = q.guard[p] - 1'b1;
      end
    end

    // Address and data are taken apart; the write runs once both are in.
    if (awvalid && q.aw_rdy) begin
      d.awg = 1'b1;
      d.awa = awaddr;
    end
    if (wvalid && q.w_rdy) begin
      d.wg = 1'b1;
      d.wd = wdata;
      d.ws = wstrb;
    end
    if (q.awg && q.wg) begin
      d.awg = 1'b0;
      d.wg  = 1'b0;
      d.bv  = 1'b1;
      d.br  = psc_pkg::RESP_OKAY;
      case (q.awa)
        psc_pkg::ADDR_CTRL: begin
          for (int p = 0; p < NP; p++) begin
            if (q.ws[p]) begin
              // A start in the guard window would hit abort processing.
              if (q.wd[p*LW + psc_pkg::CTL_RUN]) begin
                if (q.guard[p] != '0) begin
                  d.reject[p] = 1'b1;
                end else begin
                  d.run[p] = 1'b1;
                end
              end
              d.abort_sw[p] = q.wd[p*LW + psc_pkg::CTL_ABORT];
              if (q.wd[p*LW + psc_pkg::CTL_ABORT] && !q.abort_sw[p]) begin
                d.guard[p] = CW'(HOLD_CYC);
              end
              d.rst_req[p] = q.wd[p*LW + psc_pkg::CTL_RESTART];
            end
          end
        end
        psc_pkg::ADDR_STATUS: begin
          for (int p = 0; p < NP; p++) begin
            if (q.ws[p] && q.wd[p*LW + psc_pkg::ST_CONFLICT]) begin
              d.conflict[p] = 1'b0;
            end
            if (q.ws[p] && q.wd[p*LW + psc_pkg::ST_REJECT]) begin
              d.reject[p] = 1'b0;
            end
          end
        end
        psc_pkg::ADDR_INFO: begin
          d.br = psc_pkg::RESP_OKAY;
        end
        default: begin
          d.br = psc_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (q.bv && bready) begin
      d.bv = 1'b0;
    end

    if (arvalid && q.ar_rdy) begin
      d.rv = 1'b1;
      d.rr = psc_pkg::RESP_OKAY;
      case (araddr)
        psc_pkg::ADDR_CTRL:   d.rd = ctrl_w;
        psc_pkg::ADDR_STATUS: d.rd = stat_w;
        psc_pkg::ADDR_INFO:   d.rd = info_w;
        default: begin
          d.rd = '0;
          d.rr = psc_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (q.rv && rready) begin
      d.rv = 1'b0;
    end

    // Device events come after the clears so a same-cycle event survives.
    for (int p = 0; p < NP; p++) begin
      if (ssa.sequence_conflict_fatal_error[p]) begin
        d.conflict[p] = 1'b1;
      end
      if (ssa.run_rejected[p]) begin
        d.reject[p] = 1'b1;
      end
      // The guard holds the bit even if software drops it early.
      d.abort_out[p] = d.abort_sw[p] || (d.guard[p] != '0);
    end
    d.aw_rdy = !d.awg && !d.bv;
    d.w_rdy  = !d.wg && !d.bv;
    d.ar_rdy = !d.rv;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign awready                   = q.aw_rdy;
  assign wready                    = q.w_rdy;
  assign bvalid                    = q.bv;
  assign bresp                     = q.br;
  assign arready                   = q.ar_rdy;
  assign rvalid                    = q.rv;
  assign rdata                     = q.rd;
  assign rresp                     = q.rr;
  assign ssa.run_protocol_sequence = q.run;
  assign ssa.abort_bit             = q.abort_out;
  assign ssa.restart_req           = q.rst_req;

endmodule // plc_cpu_end

//--- verification/special_status_area_assertions.sv
// Concurrent checks on the status link between the host end and the board end.
`timescale 1ns/100ps
module special_status_area_assertions #(
  parameter int ABORT_CYC = psc_pkg::ABORT_CYC
) (
  // Clock and reset
  input wire logic            clk,
  input wire logic            rst,
  // Host to board
  input wire logic [1:0]      run_protocol_sequence,
  input wire logic [1:0]      abort_bit,
  input wire logic [1:0]      restart_req,
  // Board to host
  input wire logic [1:0]      exec_flag,
  input wire logic [1:0]      step_err_flag,
  input wire logic [1:0]      seq_end_flag,
  input wire logic [1:0]      seq_abort_flag,
  input wire logic [1:0]      restart_bit,
  input wire logic [1:0]      stored_flag,
  input wire logic [1:0]      sequence_conflict_fatal_error,
  input wire logic [1:0]      run_rejected,
  input wire logic [1:0][3:0] case_no,
  input wire logic [1:0][3:0] step_no,
  input wire logic [1:0][7:0] repeat_cnt
);
  // Slack for the cycle before abort processing starts counting.
  localparam int ABT_MAX = ABORT_CYC + 6;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  for (genvar p = 0; p < 2; p++) begin : g_port
    a_exec_cause:
      assert property ($rose(exec_flag[p]) |-> $past(run_protocol_sequence[p]))
      else $error("exec without run");
    a_abort_drop:
      assert property ($rose(abort_bit[p]) && exec_flag[p] |=> !exec_flag[p])
      else $error("exec kept on abort");
    a_busy_reject:
      assert property (run_protocol_sequence[p] && exec_flag[p]
        |=> ($past(restart_bit[p]) ? sequence_conflict_fatal_error[p] : run_rejected[p]))
      else $error("busy run not refused");
    a_abort_early:
      assert property ($rose(abort_bit[p]) && exec_flag[p] |=> (!seq_abort_flag[p]) [*8])
      else $error("early abort flag");
    a_abort_done:
      assert property ($rose(abort_bit[p]) && exec_flag[p]
        |-> ##[1:ABT_MAX] (seq_abort_flag[p] || !abort_bit[p]))
      else $error("abort not finished");
    a_start_clean:
      assert property ($rose(exec_flag[p])
        |-> !seq_end_flag[p] && !seq_abort_flag[p] && !step_err_flag[p])
      else $error("stale result flags");
    a_end_after:
      assert property ($rose(seq_end_flag[p]) |-> !exec_flag[p] && $past(exec_flag[p]))
      else $error("end without finish");
    a_restart_keep:
      assert property (restart_bit[p] && exec_flag[p]
        |=> exec_flag[p] || seq_end_flag[p] || abort_bit[p])
      else $error("restart cancelled run");
    a_restart_clear:
      assert property (restart_bit[p] && !exec_flag[p] && !abort_bit[p]
        |-> ##[1:2] (!restart_bit[p] && !stored_flag[p] && case_no[p] == 4'h0))
      else $error("restart incomplete");
    a_store_flag:
      assert property (($changed(case_no[p]) && case_no[p] != 4'h0)
        || ($changed(step_no[p]) && step_no[p] != 4'h0) |-> stored_flag[p])
      else $error("stored flag missing");
  end
  cover property ($fell(restart_bit[0]));
  cover property ($rose(seq_abort_flag[1]));
  cover property (run_rejected[0]);
  cover property ($rose(seq_end_flag[1]));
endmodule // special_status_area_assertions

//--- verification/tb.sv
// Self-checking bench joining the host end and the board end over the status link.
`timescale 1ns/100ps
module tb;
  logic            clk, rst;
  logic            awvalid, awready, wvalid, wready, bvalid, bready;
  logic            arvalid, arready, rvalid, rready;
  logic [3:0]      awaddr, araddr, wstrb;
  logic [31:0]     wdata, rdata;
  logic [1:0]      bresp, rresp, busy, rxv, rxo_v, bi, rc;
  logic [5:0][1:0] evt;
  logic [1:0][3:0] cval, sval;
  logic [1:0][7:0] rep, rxd, rxo_d;
  logic [7:0]      rxo_last [2];
  int              err_count, n_compared, tcnt;
  int              bi_n [2], rc_n [2], rxo_n [2];
  localparam logic [3:0] AC = psc_pkg::ADDR_CTRL, AS = psc_pkg::ADDR_STATUS;
  localparam logic [3:0] AI = psc_pkg::ADDR_INFO;

  special_status_area_if link ();
  plc_cpu_end #(.HOLD_CYC(30)) plc_cpu_end_i (
    .clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .ssa(link));
  comm_board_end #(.ABORT_CYC(20)) comm_board_end_i (
    .clk(clk), .rst(rst), .ssa(link), .seq_start(), .seq_stop(), .buf_init(bi),
    .rx_clear(rc), .step_fail(evt[0]), .step_retry_ok(evt[1]), .seq_done_ok(evt[2]),
    .seq_done_abort(evt[3]), .case_wr(evt[4]), .case_val(cval), .step_wr(evt[5]),
    .step_val(sval), .rep_val(rep), .send_busy(busy), .rx_valid(rxv), .rx_data(rxd),
    .rx_out_valid(rxo_v), .rx_out_data(rxo_d));
  special_status_area_assertions #(.ABORT_CYC(20)) chk_i (
    .clk(clk), .rst(rst), .run_protocol_sequence(link.run_protocol_sequence),
    .abort_bit(link.abort_bit), .restart_req(link.restart_req), .exec_flag(link.exec_flag),
    .step_err_flag(link.step_err_flag), .seq_end_flag(link.seq_end_flag),
    .seq_abort_flag(link.seq_abort_flag), .restart_bit(link.restart_bit),
    .stored_flag(link.stored_flag),
    .sequence_conflict_fatal_error(link.sequence_conflict_fatal_error),
    .run_rejected(link.run_rejected), .case_no(link.case_no), .step_no(link.step_no),
    .repeat_cnt(link.repeat_cnt));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic complete_run();
    if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Counters read pre-edge values, so each pulse counts once.
  always @(posedge clk) begin
    for (int p = 0; p < 2; p++) begin
      if (bi[p] === 1'b1) bi_n[p]++;
      if (rc[p] === 1'b1) rc_n[p]++;
      if (rxo_v[p] === 1'b1) begin
        rxo_n[p]++;
        rxo_last[p] = rxo_d[p];
      end
    end
    tcnt++;
    if (tcnt == 5000) begin
      err_count++;
      complete_run();
    end
  end

  function automatic logic [31:0] lane(input int p, input logic [7:0] v);
    return 32'(v) << (8 * p);
  endfunction
  // Port A ends with a normal end and a conflict before port B runs.
  function automatic logic [31:0] exp_st(input int p, input logic [7:0] v);
    return lane(p, v) | (p == 1 ? lane(0, 8'h44) : 32'h0);
  endfunction
  function automatic logic [31:0] info(input int p, input logic [3:0] c, s,
    input logic [7:0] r);
    return 32'({r, s, c}) << (16 * p);
  endfunction

  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hf;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input string nm);
    logic [1:0] r;
    axw(a, d, r);
    chk32(nm, 32'(psc_pkg::RESP_OKAY), 32'(r));
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    chk32(nm, 32'(psc_pkg::RESP_OKAY), 32'(r));
    chk32(nm, e, d);
  endtask

  task automatic ev(input int k, input int p);
    @(posedge clk);
    evt[k][p] <= 1'b1;
    @(posedge clk);
    evt <= '0;
  endtask

  initial begin
    logic [3:0]  c, s;
    logic [7:0]  r, d;
    logic [31:0] rdv;
    logic [1:0]  rs;
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wstrb, wdata} = '0;
    {evt, cval, sval, rep, busy, rxv, rxd} = '0;
    void'($urandom(32'h1f5801cb));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(AC, 32'h0, "ctrl reset");
    rd(AS, 32'h0, "status reset");
    rd(AI, 32'h0, "info reset");
    axr(4'hc, rdv, rs);
    chk32("unmapped rresp", 32'(psc_pkg::RESP_SLVERR), 32'(rs));
    chk32("unmapped rdata", 32'h0, rdv);
    axw(4'hc, 32'hffff_ffff, rs);
    chk32("unmapped write", 32'(psc_pkg::RESP_SLVERR), 32'(rs));
    for (int p = 0; p < 2; p++) begin
      wr(AC, lane(p, 8'h01), "run");
      rd(AS, exp_st(p, 8'h01), "exec");
      ev(0, p);
      rd(AS, exp_st(p, 8'h03), "step err");
      ev(1, p);
      rd(AS, exp_st(p, 8'h01), "retry ok");
      ev(0, p);
      // Dropped during the send, kept once the send has settled.
      busy[p] <= 1'b1;
      rxv[p]  <= 1'b1;
      rxd[p]  <= 8'($urandom);
      @(posedge clk);
      rxv <= '0;
      @(posedge clk);
      busy <= '0;
      repeat (3) @(posedge clk);
      d = 8'($urandom);
      rxv[p] <= 1'b1;
      rxd[p] <= d;
      @(posedge clk);
      rxv <= '0;
      repeat (2) @(posedge clk);
      chk32("rx count", 32'h1, 32'(rxo_n[p]));
      chk32("rx data", 32'(d), 32'(rxo_last[p]));
      ev(2, p);
      rd(AS, exp_st(p, 8'h06), "end");
      wr(AC, lane(p, 8'h01), "run again");
      wr(AC, lane(p, 8'h01), "run busy");
      rd(AS, exp_st(p, 8'h81), "reject");
      wr(AS, lane(p, 8'h80), "w1c");
      wr(AC, lane(p, 8'h02), "abort");
      rd(AS, exp_st(p, 8'h00), "abort exec");
      wr(AC, lane(p, 8'h03), "run guard");
      repeat (30) @(posedge clk);
      rd(AS, exp_st(p, 8'h88), "aborted");
      rd(AC, lane(p, 8'h02), "abort readback");
      wr(AC, 32'h0, "release");
      wr(AS, lane(p, 8'h80), "w1c");
      wr(AC, lane(p, 8'h01), "run third");
      rd(AS, exp_st(p, 8'h01), "fresh start");
      c = p ? 4'hf : 4'($urandom);
      s = p ? 4'hf : 4'($urandom);
      r = p ? 8'hff : 8'($urandom);
      cval[p] <= c;
      sval[p] <= s;
      rep[p]  <= r;
      ev(4, p);
      ev(5, p);
      rd(AI, info(p, c, s, r), "info");
      rd(AS, exp_st(p, 8'h21), "stored");
      wr(AC, lane(p, 8'h04), "restart");
      wr(AC, lane(p, 8'h01), "run restart");
      rd(AS, exp_st(p, 8'h71), "restart busy");
      rep[p] <= 8'h00;
      ev(2, p);
      repeat (3) @(posedge clk);
      rd(AS, exp_st(p, 8'h44), "restart done");
      rd(AI, 32'h0, "info cleared");
      chk32("buf init", 32'h1, 32'(bi_n[p]));
      chk32("rx clear", 32'h5, 32'(rc_n[p]));
    end
    complete_run();
  end
endmodule // tb
